//--- hdl/cable_diag_cfg.svh
`ifndef CABLE_DIAG_CFG_SVH
`define CABLE_DIAG_CFG_SVH

// ==========================================================================
// Register addresses, page 2
// ==========================================================================
`define ADDR_PULSE_CTRL      5'h16
`define ADDR_SAMPLE_WINDOW   5'h17
`define ADDR_PEAK_RESULT     5'h18
`define ADDR_THRESH_RESULT   5'h19
`define ADDR_VAR_CONTROL     5'h1A
`define ADDR_VAR_DATA        5'h1B

// ==========================================================================
// Pulse control fields
// ==========================================================================
`define PC_TX_CHANNEL_BIT    13
`define PC_RX_CHANNEL_BIT    12
`define PC_LAUNCH_BIT        11
`define PC_WIDTH_MSB         10
`define PC_WIDTH_LSB         8
`define PC_NEG_SELECT_BIT    7
`define PC_THRESH_MSB        5
`define PC_THRESH_LSB        0
`define PC_THRESH_RESET      6'h20

// ==========================================================================
// Sample window fields
// ==========================================================================
`define WIN_BEGIN_MSB        15
`define WIN_BEGIN_LSB        8
`define WIN_END_MSB          7
`define WIN_END_LSB          0
`define WIN_BEGIN_RESET      8'h00
`define WIN_END_RESET        8'hFF
`define WIN_TIME_LAST        8'hFF

// ==========================================================================
// Result fields
// ==========================================================================
`define PEAK_VALUE_MSB       13
`define PEAK_VALUE_LSB       8
`define THRESH_HIT_BIT       8

// ==========================================================================
// Variance control fields and timing
// ==========================================================================
`define VC_READY_BIT         15
`define VC_FREEZE_BIT        3
`define VC_TIMER_MSB         2
`define VC_TIMER_LSB         1
`define VC_ENABLE_BIT        0
`define VAR_TIMER_RESET      2'h0
`define VAR_UNIT_CYCLES      131072
`define VAR_UNITS_PER_CODE   2

`endif

//--- hdl/cable_diag_pkg.sv
package cable_diag_pkg;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [4:0]  addr;
		logic [15:0] wdata;
	} reg_req_t;

	typedef enum logic [0:0] {
		CAP_IDLE = 1'b0,
		CAP_RUN  = 1'b1
	} cap_state_t;

	typedef struct packed {
		cap_state_t  cap_state;
		logic [7:0]  window_begin_time;
		logic [7:0]  window_end_time;
		logic        tx_channel;
		logic        rx_channel;
		logic        launch_pulse_bit;
		logic [2:0]  pulse_width;
		logic        negative_peak_select;
		logic [5:0]  rx_threshold;
		logic        launch;
		logic [7:0]  cap_time;
		logic        peak_seen;
		logic [5:0]  peak_sample_value;
		logic [7:0]  peak_first_time;
		logic        threshold_hit_flag;
		logic [7:0]  threshold_first_time;
		logic        var_ready;
		logic        var_freeze;
		logic [1:0]  var_timer;
		logic        var_enable;
		logic [31:0] var_data;
		logic [15:0] var_high_shadow;
		logic        var_read_phase;
		logic [31:0] var_acc;
		logic [23:0] unit_cnt;
		logic [3:0]  units_done;
		logic        rvalid;
		logic [15:0] rdata;
	} state_t;

endpackage

//--- hdl/sample_judge.sv
`timescale 1ns/100ps

module sample_judge #(
	parameter int WIDTH = 6
) (
	input  wire logic [WIDTH-1:0] sample_in,     // Current sample
	input  wire logic [WIDTH-1:0] peak_in,       // Best sample so far
	input  wire logic [WIDTH-1:0] threshold_in,  // Trigger level
	input  wire logic             negative_in,   // 1: look for minimum
	output logic                  beats_peak_out, // Strictly better than peak
	output logic                  meets_out       // Crosses threshold
);

	// ======================================================================
	// Comparison
	// ======================================================================
	// Strict compare keeps the first occurrence of an equal peak
	always_comb begin
		if (negative_in) begin
			beats_peak_out = sample_in < peak_in;     // see R5 R6 R18
			meets_out      = sample_in < threshold_in;
		end else begin
			beats_peak_out = sample_in > peak_in;     // see R5 R6 R18
			meets_out      = sample_in > threshold_in;
		end
	end

endmodule

//--- hdl/cable_reflect_result_and_variance.sv
// Function
// R1: Window begin and end times count 8ns steps from the launched pulse.
// R2: Begin bits 15:8 reset 0, end bits 7:0 reset FF; only in-window samples count.
// R3: Software keeps window end at or above window begin before launching.
// R4: Results valid once launch bit returns to zero; software waits for that.
// R5: Six-bit peak in bits 13:8 holds maximum, or minimum in negative mode.
// R6: Bits 7:0 hold time of first peak occurrence; equal later samples ignored.
// R7: Bit 8 flags any in-window sample meeting threshold, else stays zero.
// R8: Bits 7:0 hold time of first threshold hit, meaningful only when flagged.
// R9: Reserved bits ignore writes and read zero.
// R10: Ready flag bit 15 set on new result, cleared after two data reads.
// R11: Freeze bit 3 blocks data loads, cleared after two consecutive data reads.
// R12: Timer field bits 2:1 codes 0..3 select 2,4,6,8 ms, default 0.
// R13: Writing a new timer value restarts the variance computation.
// R14: Data register loads only when the selected period has elapsed.
// R15: One timer unit equals 2^17 clock cycles.
// R16: Computation runs only while enable bit 0 is set; resets off.
// R17: Launch bit 11 sends pulse, arms capture, self-clears when capture ends.
// R18: Bit 7 selects polarity: 0 positive peak, 1 negative peak.
// R19: After freeze, first data read gives low half, second the high half.
// R20: Results are cleared at the start of each new pulse capture.
`timescale 1ns/100ps
`include "cable_diag_cfg.svh"

module cable_reflect_result_and_variance #(
	parameter int UNIT_CYCLES = `VAR_UNIT_CYCLES
) (
	input  wire logic                     clk_in,            // 125 MHz clock
	input  wire logic                     rst_in,            // Sync reset, active high
	input  wire cable_diag_pkg::reg_req_t reg_req_in,        // Management register request
	output logic                          reg_rvalid_out,    // Read data valid pulse
	output logic [15:0]                   reg_rdata_out,     // Read data
	input  wire logic [5:0]               sample_in,         // Reflected response sample
	output logic                          pulse_launch_out,  // One-cycle launch strobe
	output logic [2:0]                    pulse_width_out,   // Launch pulse width
	output logic                          tx_channel_out,    // Transmit pair select
	output logic                          rx_channel_out,    // Receive pair select
	output logic                          capture_busy_out,  // Capture in progress
	input  wire logic signed [7:0]        var_err_in,        // Receiver error sample
	input  wire logic                     var_err_valid_in,  // Error sample strobe
	output logic                          var_ready_out      // Variance result ready
);

	// ======================================================================
	// State
	// ======================================================================
	cable_diag_pkg::state_t st_q;
	cable_diag_pkg::state_t st_d;

	logic        beats_peak;
	logic        meets_thr;
	logic        in_window;
	logic        cap_last;
	logic        wr_ctrl;
	logic        wr_window;
	logic        wr_var;
	logic        rd_data;
	logic        rd_other;
	logic [3:0]  period_units;
	logic        unit_tick;
	logic        period_done;
	logic [15:0] err_sq;

	sample_judge #(
		.WIDTH (6)
	) u_judge (
		.sample_in      (sample_in),
		.peak_in        (st_q.peak_sample_value),
		.threshold_in   (st_q.rx_threshold),
		.negative_in    (st_q.negative_peak_select),
		.beats_peak_out (beats_peak),
		.meets_out      (meets_thr)
	);

	// ======================================================================
	// Decode
	// ======================================================================
	always_comb begin
		wr_ctrl   = 1'b0;
		wr_window = 1'b0;
		wr_var    = 1'b0;
		rd_data   = 1'b0;
		rd_other  = 1'b0;
		if (reg_req_in.wr && reg_req_in.addr == `ADDR_PULSE_CTRL) begin
			wr_ctrl = 1'b1;
		end else if (reg_req_in.wr && reg_req_in.addr == `ADDR_SAMPLE_WINDOW) begin
			wr_window = 1'b1;
		end else if (reg_req_in.wr && reg_req_in.addr == `ADDR_VAR_CONTROL) begin
			wr_var = 1'b1;
		end
		if (reg_req_in.rd && reg_req_in.addr == `ADDR_VAR_DATA) begin
			rd_data = 1'b1;
		end else if (reg_req_in.rd) begin
			rd_other = 1'b1;
		end
	end

	// ======================================================================
	// Capture window and variance timing
	// ======================================================================
	always_comb begin
		// Inclusive window in 8ns steps since launch
		in_window = (st_q.cap_time >= st_q.window_begin_time) &&
		            (st_q.cap_time <= st_q.window_end_time);       // see R1 R2
		// Stop at window end; a reversed window simply sees no samples
		cap_last  = (st_q.cap_time == st_q.window_end_time) ||
		            (st_q.cap_time == `WIN_TIME_LAST);             // see R2
		period_units = 4'((32'(st_q.var_timer) + 32'd1) * `VAR_UNITS_PER_CODE); // see R12
		unit_tick    = st_q.unit_cnt == 24'(UNIT_CYCLES - 1);      // see R15
		period_done  = unit_tick && (st_q.units_done == 4'(period_units - 4'h1));
		// Widen before multiplying so the square is not cut to 8 bits
		err_sq       = 16'(32'(var_err_in) * 32'(var_err_in));
	end

	// ======================================================================
	// Next state
	// ======================================================================
	always_comb begin
		st_d        = st_q;
		st_d.launch = 1'b0;
		st_d.rvalid = reg_req_in.rd;

		// Pulse control and window writes
		if (wr_ctrl) begin
			st_d.tx_channel           = reg_req_in.wdata[`PC_TX_CHANNEL_BIT];
			st_d.rx_channel           = reg_req_in.wdata[`PC_RX_CHANNEL_BIT];
			st_d.pulse_width          = reg_req_in.wdata[`PC_WIDTH_MSB:`PC_WIDTH_LSB];
			st_d.negative_peak_select = reg_req_in.wdata[`PC_NEG_SELECT_BIT]; // see R18
			st_d.rx_threshold         = reg_req_in.wdata[`PC_THRESH_MSB:`PC_THRESH_LSB];
		end
		if (wr_window) begin
			st_d.window_begin_time = reg_req_in.wdata[`WIN_BEGIN_MSB:`WIN_BEGIN_LSB]; // see R2
			st_d.window_end_time   = reg_req_in.wdata[`WIN_END_MSB:`WIN_END_LSB];
		end

		// Capture engine
		case (st_q.cap_state)
			cable_diag_pkg::CAP_IDLE: begin
				if (wr_ctrl && reg_req_in.wdata[`PC_LAUNCH_BIT]) begin
					st_d.cap_state            = cable_diag_pkg::CAP_RUN;
					st_d.launch_pulse_bit     = 1'b1;              // see R17
					st_d.launch               = 1'b1;
					st_d.cap_time             = 8'h00;
					// Old results must never look valid for the new pulse
					st_d.peak_seen            = 1'b0;              // see R20
					st_d.peak_sample_value    = 6'h00;
					st_d.peak_first_time      = 8'h00;
					st_d.threshold_hit_flag   = 1'b0;
					st_d.threshold_first_time = 8'h00;
				end
			end
			cable_diag_pkg::CAP_RUN: begin
				if (in_window) begin
					if (!st_q.peak_seen || beats_peak) begin
						st_d.peak_seen         = 1'b1;
						st_d.peak_sample_value = sample_in;        // see R5
						st_d.peak_first_time   = st_q.cap_time;    // see R6
					end
					if (meets_thr && !st_q.threshold_hit_flag) begin
						st_d.threshold_hit_flag   = 1'b1;          // see R7
						st_d.threshold_first_time = st_q.cap_time; // see R8
					end
				end
				if (cap_last) begin
					st_d.cap_state        = cable_diag_pkg::CAP_IDLE;
					st_d.launch_pulse_bit = 1'b0;                  // see R4 R17
				end else begin
					st_d.cap_time = st_q.cap_time + 8'h01;
				end
			end
			default: begin
				st_d.cap_state = cable_diag_pkg::CAP_IDLE;
			end
		endcase

		// Variance data reads: low half first, then high half
		if (rd_data) begin
			if (!st_q.var_read_phase) begin
				st_d.var_read_phase  = 1'b1;
				st_d.var_high_shadow = st_q.var_data[31:16];       // see R19
			end else begin
				st_d.var_read_phase = 1'b0;
				st_d.var_ready      = 1'b0;                        // see R10
				st_d.var_freeze     = 1'b0;                        // see R11
			end
		end else if (rd_other) begin
			// Any other read breaks the pair
			st_d.var_read_phase = 1'b0;
		end

		// Variance control writes
		if (wr_var) begin
			st_d.var_freeze = reg_req_in.wdata[`VC_FREEZE_BIT];
			st_d.var_timer  = reg_req_in.wdata[`VC_TIMER_MSB:`VC_TIMER_LSB]; // see R12
			st_d.var_enable = reg_req_in.wdata[`VC_ENABLE_BIT];
		end

		// Variance computation
		if (!st_q.var_enable) begin
			st_d.var_acc    = 32'h0000_0000;                       // see R16
			st_d.unit_cnt   = 24'h00_0000;
			st_d.units_done = 4'h0;
		end else if (wr_var &&
		             reg_req_in.wdata[`VC_TIMER_MSB:`VC_TIMER_LSB] != st_q.var_timer) begin
			st_d.var_acc    = 32'h0000_0000;                       // see R13
			st_d.unit_cnt   = 24'h00_0000;
			st_d.units_done = 4'h0;
		end else begin
			st_d.var_acc  = var_err_valid_in ? st_q.var_acc + 32'(err_sq) : st_q.var_acc;
			st_d.unit_cnt = unit_tick ? 24'h00_0000 : st_q.unit_cnt + 24'h00_0001;
			if (period_done) begin
				st_d.units_done = 4'h0;
				st_d.var_acc    = 32'h0000_0000;
				if (!st_q.var_freeze) begin
					st_d.var_data  = st_q.var_acc;                 // see R11 R14
					// Set beats a same-cycle clear from the read pair
					st_d.var_ready = 1'b1;                         // see R10
				end
			end else if (unit_tick) begin
				st_d.units_done = st_q.units_done + 4'h1;
			end
		end

		// Read data, reserved bits forced to zero
		st_d.rdata = 16'h0000;
		if (reg_req_in.rd && reg_req_in.addr == `ADDR_PULSE_CTRL) begin
			st_d.rdata[`PC_TX_CHANNEL_BIT]            = st_q.tx_channel;
			st_d.rdata[`PC_RX_CHANNEL_BIT]            = st_q.rx_channel;
			st_d.rdata[`PC_LAUNCH_BIT]                = st_q.launch_pulse_bit;
			st_d.rdata[`PC_WIDTH_MSB:`PC_WIDTH_LSB]   = st_q.pulse_width;
			st_d.rdata[`PC_NEG_SELECT_BIT]            = st_q.negative_peak_select;
			st_d.rdata[`PC_THRESH_MSB:`PC_THRESH_LSB] = st_q.rx_threshold;
		end else if (reg_req_in.rd && reg_req_in.addr == `ADDR_SAMPLE_WINDOW) begin
			st_d.rdata[`WIN_BEGIN_MSB:`WIN_BEGIN_LSB] = st_q.window_begin_time;
			st_d.rdata[`WIN_END_MSB:`WIN_END_LSB]     = st_q.window_end_time;
		end else if (reg_req_in.rd && reg_req_in.addr == `ADDR_PEAK_RESULT) begin
			st_d.rdata[`PEAK_VALUE_MSB:`PEAK_VALUE_LSB] = st_q.peak_sample_value; // see R9
			st_d.rdata[7:0]                             = st_q.peak_first_time;
		end else if (reg_req_in.rd && reg_req_in.addr == `ADDR_THRESH_RESULT) begin
			st_d.rdata[`THRESH_HIT_BIT] = st_q.threshold_hit_flag;               // see R9
			st_d.rdata[7:0]             = st_q.threshold_first_time;
		end else if (reg_req_in.rd && reg_req_in.addr == `ADDR_VAR_CONTROL) begin
			st_d.rdata[`VC_READY_BIT]              = st_q.var_ready;            // see R9
			st_d.rdata[`VC_FREEZE_BIT]             = st_q.var_freeze;
			st_d.rdata[`VC_TIMER_MSB:`VC_TIMER_LSB] = st_q.var_timer;
			st_d.rdata[`VC_ENABLE_BIT]             = st_q.var_enable;
		end else if (rd_data) begin
			st_d.rdata = st_q.var_read_phase ? st_q.var_high_shadow
			                                 : st_q.var_data[15:0];            // see R19
		end
	end

	// ======================================================================
	// Registers
	// ======================================================================
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			st_q                      <= '0;
			st_q.cap_state            <= cable_diag_pkg::CAP_IDLE;
			st_q.window_begin_time    <= `WIN_BEGIN_RESET;          // see R2
			st_q.window_end_time      <= `WIN_END_RESET;
			st_q.rx_threshold         <= `PC_THRESH_RESET;
			st_q.var_timer            <= `VAR_TIMER_RESET;          // see R12
			st_q.var_enable           <= 1'b0;                      // see R16
		end else begin
			st_q <= st_d;
		end
	end

	// ======================================================================
	// Outputs
	// ======================================================================
	assign reg_rvalid_out   = st_q.rvalid;
	assign reg_rdata_out    = st_q.rdata;
	assign pulse_launch_out = st_q.launch;
	assign pulse_width_out  = st_q.pulse_width;
	assign tx_channel_out   = st_q.tx_channel;
	assign rx_channel_out   = st_q.rx_channel;
	assign capture_busy_out = st_q.launch_pulse_bit;
	assign var_ready_out    = st_q.var_ready;

endmodule

//--- bench/cable_diag_checker.sv
`timescale 1ns/100ps
module cable_diag_checker #(
	parameter int UNIT_CYCLES = 8
) (
	input wire logic                     clk_in,           // Clock
	input wire logic                     rst_in,           // Sync reset
	input wire cable_diag_pkg::reg_req_t reg_req_in,       // Register request
	input wire logic                     reg_rvalid_out,   // Read valid
	input wire logic [15:0]              reg_rdata_out,    // Read data
	input wire logic                     pulse_launch_out, // Launch strobe
	input wire logic [2:0]               pulse_width_out,  // Pulse width
	input wire logic                     tx_channel_out,   // Transmit pair
	input wire logic                     capture_busy_out, // Capture busy
	input wire logic                     var_ready_out     // Variance ready
);
	// ==========================================================
	// Register port and capture relations
	// ==========================================================
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);

	read_answer_a: assert property (
		reg_req_in.rd |=> reg_rvalid_out) else $error("read not answered");
	no_spurious_a: assert property (
		!reg_req_in.rd |=> !reg_rvalid_out) else $error("unrequested read valid");
	idle_data_a: assert property (
		!reg_rvalid_out |-> reg_rdata_out == 16'h0000) else $error("data outside valid");
	launch_start_a: assert property (
		reg_req_in.wr && reg_req_in.addr == 5'h16 && reg_req_in.wdata[11] && !capture_busy_out
		|=> pulse_launch_out && capture_busy_out) else $error("launch not started");
	launch_once_a: assert property (
		pulse_launch_out |-> capture_busy_out && !$past(capture_busy_out))
		else $error("launch while busy");
	capture_ends_a: assert property (
		$rose(capture_busy_out) |-> ##[1:260] !capture_busy_out) else $error("capture hangs");
	ctrl_fields_a: assert property (
		reg_req_in.wr && reg_req_in.addr == 5'h16 |=> tx_channel_out == $past(reg_req_in.wdata[13])
		&& pulse_width_out == $past(reg_req_in.wdata[10:8])) else $error("control not applied");
	ready_clear_a: assert property (
		$fell(var_ready_out) |-> $past(reg_req_in.rd) && $past(reg_req_in.addr) == 5'h1B
		|| $past(reg_req_in.wr) && $past(reg_req_in.addr) == 5'h1A) else $error("ready lost");
endmodule

//--- bench/cable_reflect_result_and_variance_tb.sv
`timescale 1ns/100ps
module cable_reflect_result_and_variance_tb;
	localparam int UNIT = 8;
	logic                     clk_in, rst_in, var_err_valid_in, reg_rvalid_out, pulse_launch_out;
	logic                     tx_channel_out, rx_channel_out, capture_busy_out, var_ready_out;
	logic [15:0]              reg_rdata_out, d, lo;
	logic [5:0]               sample_in;
	logic [2:0]               pulse_width_out;
	logic signed [7:0]        var_err_in;
	cable_diag_pkg::reg_req_t req;
	int                       error_cnt, tests_run, n;
	logic [5:0]               smp [12] = '{6'h3F, 6'h10, 6'h12, 6'h15, 6'h22, 6'h30,
	                                       6'h30, 6'h25, 6'h33, 6'h33, 6'h21, 6'h3F};
	logic [4:0]               ra [6] = '{5'h16, 5'h17, 5'h18, 5'h19, 5'h1A, 5'h05};
	logic [15:0]              rv [6] = '{16'h0020, 16'h00FF, 16'h0, 16'h0, 16'h0, 16'h0};

	cable_reflect_result_and_variance #(.UNIT_CYCLES(UNIT)) i_cable_reflect_result_and_variance (
		.clk_in(clk_in), .rst_in(rst_in), .reg_req_in(req), .reg_rvalid_out(reg_rvalid_out),
		.reg_rdata_out(reg_rdata_out), .sample_in(sample_in), .pulse_launch_out(pulse_launch_out),
		.pulse_width_out(pulse_width_out), .tx_channel_out(tx_channel_out),
		.rx_channel_out(rx_channel_out), .capture_busy_out(capture_busy_out),
		.var_err_in(var_err_in), .var_err_valid_in(var_err_valid_in),
		.var_ready_out(var_ready_out));

	// ==========================================================
	// Access tasks
	// ==========================================================
	task automatic wrap_up();
		if (error_cnt == 0 && tests_run > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR %0t: got %h expected %h", $time, seen, exp);
		end
	endtask

	// Extra idle cycle keeps the strobe from being re-driven in one step
	task automatic wr(input logic [4:0] a, input logic [15:0] v);
		req = '{1'b1, 1'b0, a, v};
		@(negedge clk_in);
		req = '0;
		@(negedge clk_in);
	endtask

	task automatic rd(input logic [4:0] a, output logic [15:0] v);
		req = '{1'b0, 1'b1, a, 16'h0000};
		@(negedge clk_in);
		req = '0;
		chk({15'h0, reg_rvalid_out}, 16'h0001);
		v = reg_rdata_out;
		@(negedge clk_in);
	endtask

	// Sample t is presented so that the edge one cycle after the launch edge sees t=0
	task automatic capture(input logic [15:0] ctrl);
		req = '{1'b1, 1'b0, 5'h16, ctrl};
		@(negedge clk_in);
		req = '0;
		chk({15'h0, pulse_launch_out}, 16'h0001);
		for (int t = 0; t < 12; t++) begin
			sample_in = smp[t];
			@(negedge clk_in);
		end
		for (n = 0; n < 300 && capture_busy_out !== 1'b0; n++) @(negedge clk_in);
		if (n == 300) begin
			error_cnt++;
			wrap_up();
		end
	endtask

	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end

	// ==========================================================
	// Main sequence
	// ==========================================================
	initial begin
		rst_in = 1'b1;
		req = '0;
		sample_in = 6'h00;
		var_err_in = 8'sh02;
		var_err_valid_in = 1'b1;
		error_cnt = 0;
		tests_run = 0;
		repeat (20) @(negedge clk_in);
		rst_in = 1'b0;
		for (int i = 0; i < 6; i++) begin
			rd(ra[i], d);
			chk(d, rv[i]);
		end
		wr(5'h17, 16'h040A);
		wr(5'h18, 16'hFFFF);
		wr(5'h19, 16'hFFFF);
		wr(5'h1A, 16'h7FF0);
		rd(5'h17, d);
		chk(d, 16'h040A);
		rd(5'h18, d);
		chk(d, 16'h0000);
		rd(5'h19, d);
		chk(d, 16'h0000);
		rd(5'h1A, d);
		chk(d, 16'h0000);
		// Window 4..10: samples outside it must not win
		capture(16'h0820);
		rd(5'h16, d);
		chk(d, 16'h0020);
		rd(5'h18, d);
		chk(d, 16'h3308);
		rd(5'h19, d);
		chk(d, 16'h0104);
		capture(16'h08A0);
		rd(5'h18, d);
		chk(d, 16'h210A);
		rd(5'h19, d);
		chk(d & 16'hFF00, 16'h0000);
		// Each timer code restarts the period; two data reads clear ready
		for (int c = 1; c < 5; c++) begin
			wr(5'h1A, {13'h0, 2'(c % 4), 1'b1});
			rd(5'h1B, d);
			rd(5'h1B, d);
			for (n = 4; n < 200 && var_ready_out !== 1'b1; n++) @(negedge clk_in);
			if (n == 200) begin
				error_cnt++;
				wrap_up();
			end
			chk(16'(n >= (c % 4 + 1) * 2 * UNIT - 5 && n <= (c % 4 + 1) * 2 * UNIT + 3), 16'h1);
		end
		// Whole freeze sequence fits inside one period after ready rose
		wr(5'h1A, 16'h0009);
		rd(5'h1A, d);
		chk(d, 16'h8009);
		rd(5'h1B, lo);
		rd(5'h1B, d);
		chk(d, 16'h0000);
		chk(16'(lo != 16'h0 && lo[1:0] == 2'b00), 16'h1);
		rd(5'h1A, d);
		chk(d, 16'h0001);
		wr(5'h1A, 16'h0000);
		n = 0;
		repeat (40) begin
			@(negedge clk_in);
			n += (var_ready_out !== 1'b0);
		end
		chk(16'(n), 16'h0000);
		wr(5'h16, 16'h3725);
		chk({11'h0, tx_channel_out, rx_channel_out, pulse_width_out}, 16'h001F);
		rd(5'h16, d);
		chk(d, 16'h3725);
		wrap_up();
	end
endmodule

bind cable_reflect_result_and_variance cable_diag_checker #(.UNIT_CYCLES(UNIT_CYCLES)) i_cable_diag_checker (
	.clk_in(clk_in), .rst_in(rst_in), .reg_req_in(reg_req_in), .reg_rvalid_out(reg_rvalid_out),
	.reg_rdata_out(reg_rdata_out), .pulse_launch_out(pulse_launch_out),
	.pulse_width_out(pulse_width_out), .tx_channel_out(tx_channel_out),
	.capture_busy_out(capture_busy_out), .var_ready_out(var_ready_out));
